//--- hdl/sbp_top.sv
// Execution datapath for the signed byte multiply instruction.
// Function
// - The accumulator is multiplied by the source byte and the whole 16-bit product goes to the product pair.
// - The accumulator and the source operand are only copied, never written back, so both keep their values.
// - Carry is 1 when the upper product byte is more than a sign extension of the lower byte, else 0.
// - Sign is set when the 16-bit product is negative and cleared otherwise.
// - Zero is set for a zero product, overflow is always cleared, half-carry and subtract keep their values.
// - An index half select of 100 takes the upper byte and 101 the lower byte.
// - A long index select of 001 uses the first index plus displacement and 010 the second.
// - A base index select of 001 uses the product pair plus first index and 010 the pair plus second index.
`timescale 1ns/1ps
`default_nettype none
module sbp_top
    import sbp_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic        CLK_SYS_IN,         // Core clock, 25 MHz.
    input  wire logic        RST_N_IN,           // Asynchronous reset, active low.
    input  wire logic        START_IN,           // Pulse: begin one multiply.
    input  wire logic [3:0]  SRC_FORM_IN,        // Source operand form.
    input  wire logic [7:0]  ACC_IN,             // Accumulator value.
    input  wire logic [7:0]  REG_IN,             // Register operand.
    input  wire logic [7:0]  IMM_IN,             // Immediate operand.
    input  wire logic        IDX_SEL_IN,         // 0 first index, 1 second index.
    input  wire logic [2:0]  HALF_SEL_IN,        // Index half select field.
    input  wire logic [2:0]  LONG_INDEX_SEL_IN,  // Long index select field.
    input  wire logic [2:0]  BASE_INDEX_SEL_IN,  // Base index select field.
    input  wire logic [15:0] FIRST_INDEX_IN,     // First index register.
    input  wire logic [15:0] SECOND_INDEX_IN,    // Second index register.
    input  wire logic [15:0] PRODUCT_PAIR_IN,    // Current product pair.
    input  wire logic [15:0] SP_IN,              // Stack pointer.
    input  wire logic [15:0] PC_IN,              // Program counter after the instruction.
    input  wire logic [15:0] DISP_IN,            // Displacement or direct address.
    input  wire logic [7:0]  FLAGS_IN,           // Flag byte before execution.
    input  wire logic        MEM_VALID_IN,       // Pulse: memory operand returned.
    input  wire logic [7:0]  MEM_DATA_IN,        // Memory operand byte.
    output logic      [15:0] ADDR_OUT,           // Operand address.
    output logic             ADDR_VALID_OUT,     // Level: memory read pending.
    output logic      [15:0] PRODUCT_PAIR_OUT,   // New product pair value.
    output logic             PRODUCT_WE_OUT,     // Pulse: write product pair.
    output logic      [7:0]  FLAGS_OUT,          // New flag byte.
    output logic             FLAGS_WE_OUT,       // Pulse: write flags.
    output logic             DONE_OUT,           // Pulse: instruction finished.
    output logic             FORM_ERR_OUT        // Pulse: unsupported field code.
);
    // The datapath and flag layout are built for byte operands only.
    if (DATA_W != 8) begin : g_width_check
        $error("sbp_top supports DATA_W of 8 only");
    end

    // Effective address with a sign-extended short displacement.
    function automatic logic [15:0] sbp_short_addr(input logic [15:0] base, input logic [7:0] d);
        sbp_short_addr = base + {{8{d[7]}}, d};
    endfunction

    sbp_state_e  state_ff, nxt_state;
    logic [7:0]  acc_ff, nxt_acc;
    logic [7:0]  src_ff, nxt_src;
    logic [7:0]  flg_ff, nxt_flg;
    logic [15:0] addr_ff, nxt_addr;
    logic        addr_vld_ff, nxt_addr_vld;
    logic [15:0] prod_ff, nxt_prod;
    logic        we_ff, nxt_we;
    logic [7:0]  flags_out_ff, nxt_flags_out;
    logic        done_ff, nxt_done;
    logic        err_ff, nxt_err;
    logic [15:0] sel_index;

    sbp_mul_if #(.DATA_W(DATA_W)) mul_bus ();

    sbp_mul_core #(.DATA_W(DATA_W)) u_core (
        .mul (mul_bus.core)
    );

    // The core only sees private copies; nothing here drives the accumulator or the source back.
    // operands kept intact
    assign mul_bus.mcand  = acc_ff;
    assign mul_bus.mplier = src_ff;

    assign sel_index = IDX_SEL_IN ? SECOND_INDEX_IN : FIRST_INDEX_IN;

    // Sequencer: decode the source form, fetch memory operands, then multiply.
    always_comb begin
        nxt_state     = state_ff;
        nxt_acc       = acc_ff;
        nxt_src       = src_ff;
        nxt_flg       = flg_ff;
        nxt_addr      = addr_ff;
        nxt_addr_vld  = addr_vld_ff;
        nxt_prod      = prod_ff;
        nxt_flags_out = flags_out_ff;
        nxt_we        = 1'b0;
        nxt_done      = 1'b0;
        nxt_err       = 1'b0;
        case (state_ff)
            SBP_ST_IDLE: begin
                if (START_IN) begin
                    nxt_acc   = ACC_IN;
                    nxt_flg   = FLAGS_IN;
                    nxt_state = SBP_ST_FETCH;
                    case (SRC_FORM_IN)
                        SBP_SRC_REG: begin
                            nxt_src   = REG_IN;
                            nxt_state = SBP_ST_EXEC;
                        end
                        SBP_SRC_HALF: begin
                            nxt_state = SBP_ST_EXEC;
                            if (HALF_SEL_IN == SBP_HALF_UPPER) begin
                                nxt_src = sel_index[15:8];
                            end else if (HALF_SEL_IN == SBP_HALF_LOWER) begin
                                nxt_src = sel_index[7:0];
                            end else begin
                                nxt_err   = 1'b1;
                                nxt_state = SBP_ST_IDLE;
                            end
                        end
                        SBP_SRC_IMM: begin
                            nxt_src   = IMM_IN;
                            nxt_state = SBP_ST_EXEC;
                        end
                        SBP_SRC_IND:   nxt_addr = PRODUCT_PAIR_IN;
                        SBP_SRC_DIR:   nxt_addr = DISP_IN;
                        SBP_SRC_SHORT: nxt_addr = sbp_short_addr(sel_index, DISP_IN[7:0]);
                        SBP_SRC_REL:   nxt_addr = PC_IN + DISP_IN;
                        SBP_SRC_STACK: nxt_addr = SP_IN + DISP_IN;
                        SBP_SRC_LONG: begin
                            if (LONG_INDEX_SEL_IN == SBP_LONG_FIRST) begin
                                nxt_addr = FIRST_INDEX_IN + DISP_IN;
                            end else if (LONG_INDEX_SEL_IN == SBP_LONG_SECOND) begin
                                nxt_addr = SECOND_INDEX_IN + DISP_IN;
                            end else begin
                                nxt_err   = 1'b1;
                                nxt_state = SBP_ST_IDLE;
                            end
                        end
                        SBP_SRC_BASE: begin
                            if (BASE_INDEX_SEL_IN == SBP_BASE_FIRST) begin
                                nxt_addr = PRODUCT_PAIR_IN + FIRST_INDEX_IN;
                            end else if (BASE_INDEX_SEL_IN == SBP_BASE_SECOND) begin
                                nxt_addr = PRODUCT_PAIR_IN + SECOND_INDEX_IN;
                            end else begin
                                nxt_err   = 1'b1;
                                nxt_state = SBP_ST_IDLE;
                            end
                        end
                        default: begin
                            nxt_err   = 1'b1;
                            nxt_state = SBP_ST_IDLE;
                        end
                    endcase
                    nxt_addr_vld = (nxt_state == SBP_ST_FETCH);
                end
            end
            SBP_ST_FETCH: begin
                // The read stays requested until the memory side answers; no timeout exists.
                if (MEM_VALID_IN) begin
                    nxt_src      = MEM_DATA_IN;
                    nxt_addr_vld = 1'b0;
                    nxt_state    = SBP_ST_EXEC;
                end
            end
            SBP_ST_EXEC: begin
                nxt_prod      = mul_bus.prod;
                nxt_we        = 1'b1;
                nxt_flags_out = flg_ff;
                nxt_flags_out[SBP_FLAG_S] = mul_bus.sign;
                nxt_flags_out[SBP_FLAG_Z] = mul_bus.zero;
                nxt_flags_out[SBP_FLAG_V] = 1'b0;
                nxt_flags_out[SBP_FLAG_C] = mul_bus.carry;
                nxt_done  = 1'b1;
                nxt_state = SBP_ST_IDLE;
            end
            default: begin
                nxt_state    = SBP_ST_IDLE;
                nxt_addr_vld = 1'b0;
            end
        endcase
    end

    // State and output registers; every output comes straight from here.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_ff     <= SBP_ST_IDLE;
            acc_ff       <= SBP_RST_BYTE;
            src_ff       <= SBP_RST_BYTE;
            flg_ff       <= SBP_RST_BYTE;
            addr_ff      <= SBP_RST_WORD;
            addr_vld_ff  <= 1'b0;
            prod_ff      <= SBP_RST_WORD;
            we_ff        <= 1'b0;
            flags_out_ff <= SBP_RST_BYTE;
            done_ff      <= 1'b0;
            err_ff       <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            acc_ff       <= nxt_acc;
            src_ff       <= nxt_src;
            flg_ff       <= nxt_flg;
            addr_ff      <= nxt_addr;
            addr_vld_ff  <= nxt_addr_vld;
            prod_ff      <= nxt_prod;
            we_ff        <= nxt_we;
            flags_out_ff <= nxt_flags_out;
            done_ff      <= nxt_done;
            err_ff       <= nxt_err;
        end
    end

    assign ADDR_OUT         = addr_ff;
    assign ADDR_VALID_OUT   = addr_vld_ff;
    assign PRODUCT_PAIR_OUT = prod_ff;
    assign PRODUCT_WE_OUT   = we_ff;
    assign FLAGS_OUT        = flags_out_ff;
    assign FLAGS_WE_OUT     = we_ff;
    assign DONE_OUT         = done_ff;
    assign FORM_ERR_OUT     = err_ff;
endmodule : sbp_top
`default_nettype wire

//--- hdl/sbp_pkg.sv
// Constants and types shared by the signed byte multiply datapath.
package sbp_pkg;
    // Source operand forms taken by the multiply.
    typedef enum logic [3:0] {
        SBP_SRC_REG   = 4'h0,
        SBP_SRC_HALF  = 4'h1,
        SBP_SRC_IMM   = 4'h2,
        SBP_SRC_IND   = 4'h3,
        SBP_SRC_DIR   = 4'h4,
        SBP_SRC_LONG  = 4'h5,
        SBP_SRC_SHORT = 4'h6,
        SBP_SRC_REL   = 4'h7,
        SBP_SRC_STACK = 4'h8,
        SBP_SRC_BASE  = 4'h9
    } sbp_src_e;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        SBP_ST_IDLE  = 3'b001,
        SBP_ST_FETCH = 3'b010,
        SBP_ST_EXEC  = 3'b100
    } sbp_state_e;

    // Field codes for the index half, long index and base index selects.
    localparam logic [2:0] SBP_HALF_UPPER   = 3'h4;
    localparam logic [2:0] SBP_HALF_LOWER   = 3'h5;
    localparam logic [2:0] SBP_LONG_FIRST   = 3'h1;
    localparam logic [2:0] SBP_LONG_SECOND  = 3'h2;
    localparam logic [2:0] SBP_BASE_FIRST   = 3'h1;
    localparam logic [2:0] SBP_BASE_SECOND  = 3'h2;

    // Flag byte bit positions.
    localparam int SBP_FLAG_S = 7;
    localparam int SBP_FLAG_Z = 6;
    localparam int SBP_FLAG_H = 4;
    localparam int SBP_FLAG_V = 2;
    localparam int SBP_FLAG_N = 1;
    localparam int SBP_FLAG_C = 0;

    // Values after reset.
    localparam logic [15:0] SBP_RST_WORD = 16'h0000;
    localparam logic [7:0]  SBP_RST_BYTE = 8'h00;
endpackage : sbp_pkg

//--- hdl/sbp_mul_if.sv
// Interface that carries operands and results between the sequencer and the multiply core.
`timescale 1ns/1ps
`default_nettype none
interface sbp_mul_if #(parameter int DATA_W = 8);
    logic [DATA_W-1:0]   mcand;   // Accumulator copy.
    logic [DATA_W-1:0]   mplier;  // Source operand copy.
    logic [2*DATA_W-1:0] prod;    // Signed product.
    logic                carry;   // Upper half carries information.
    logic                sign;    // Product negative.
    logic                zero;    // Product is zero.

    modport core (input mcand, input mplier, output prod, output carry, output sign, output zero);
    modport user (output mcand, output mplier, input prod, input carry, input sign, input zero);
endinterface : sbp_mul_if
`default_nettype wire

//--- hdl/sbp_mul_core.sv
// Combinational signed multiplier with result flag evaluation.
`timescale 1ns/1ps
`default_nettype none
module sbp_mul_core
    import sbp_pkg::*;
#(
    parameter int DATA_W = 8
) (
    sbp_mul_if.core mul  // Operand and result bundle.
);
    logic signed [2*DATA_W-1:0] full;

    // Both operands are two's complement, so the product is signed.
    // signed operand product
    always_comb begin
        full = $signed(mul.mcand) * $signed(mul.mplier);
    end

    // Result flags derived from the full product.
    always_comb begin
        mul.prod  = full;
        mul.carry = (full[2*DATA_W-1:DATA_W-1] != {(DATA_W+1){1'b0}}) &&
                    (full[2*DATA_W-1:DATA_W-1] != {(DATA_W+1){1'b1}});
        mul.sign  = full[2*DATA_W-1];
        mul.zero  = (full == '0);
    end
endmodule : sbp_mul_core
`default_nettype wire

//--- bench/sbp_top_chk.sv
// Concurrent checks on the ports of the signed byte multiply datapath.
`timescale 1ns/1ps
`default_nettype none
module sbp_top_chk
    import sbp_pkg::*;
(
    input wire logic        CLK_SYS_IN,       // Core clock.
    input wire logic        RST_N_IN,         // Reset, active low.
    input wire logic        START_IN,         // Start pulse.
    input wire logic [3:0]  SRC_FORM_IN,      // Source form.
    input wire logic [7:0]  ACC_IN,           // Accumulator.
    input wire logic [7:0]  REG_IN,           // Register operand.
    input wire logic [7:0]  FLAGS_IN,         // Flags before.
    input wire logic [15:0] DISP_IN,          // Displacement.
    input wire logic [15:0] ADDR_OUT,         // Operand address.
    input wire logic        ADDR_VALID_OUT,   // Read pending.
    input wire logic [15:0] PRODUCT_PAIR_OUT, // Product.
    input wire logic        PRODUCT_WE_OUT,   // Product write.
    input wire logic [7:0]  FLAGS_OUT,        // Flags after.
    input wire logic        FLAGS_WE_OUT,     // Flags write.
    input wire logic        DONE_OUT,         // Done pulse.
    input wire logic        FORM_ERR_OUT      // Error pulse.
);
    logic        busy_ff;
    logic        nxt_busy;
    logic        taken;
    logic [15:0] reg_prod;
    // A start on the completion cycle is legal, so completion counts as idle here.
    assign taken = START_IN && (!busy_ff || DONE_OUT || FORM_ERR_OUT);
    assign reg_prod = 16'($signed(ACC_IN) * $signed(REG_IN));
    // Busy tracker, so that ignored starts never arm a check.
    always_comb begin
        nxt_busy = taken ? 1'b1 : ((DONE_OUT || FORM_ERR_OUT) ? 1'b0 : busy_ff);
    end
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) busy_ff <= 1'b0;
        else busy_ff <= nxt_busy;
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    chk_we_with_done: assert property (PRODUCT_WE_OUT == DONE_OUT)
        else $error("product write and done differ");
    chk_flags_we_pair: assert property (FLAGS_WE_OUT == PRODUCT_WE_OUT)
        else $error("flag write and product write differ");
    chk_ovf_cleared: assert property (DONE_OUT |-> !FLAGS_OUT[SBP_FLAG_V])
        else $error("overflow flag not cleared");
    chk_zero_flag: assert property (DONE_OUT |-> FLAGS_OUT[SBP_FLAG_Z] == (PRODUCT_PAIR_OUT == 16'h0000))
        else $error("zero flag wrong");
    chk_sign_flag: assert property (DONE_OUT |-> FLAGS_OUT[SBP_FLAG_S] == PRODUCT_PAIR_OUT[15])
        else $error("sign flag wrong");
    chk_carry_flag: assert property (DONE_OUT |->
        FLAGS_OUT[SBP_FLAG_C] == !((&PRODUCT_PAIR_OUT[15:7]) || !(|PRODUCT_PAIR_OUT[15:7])))
        else $error("carry flag wrong");
    chk_reg_latency: assert property ((taken && SRC_FORM_IN == 4'h0) |=> !DONE_OUT ##1 DONE_OUT)
        else $error("register form done not two cycles after start");
    chk_signed_product: assert property ((taken && SRC_FORM_IN == 4'h0) |-> ##2
        PRODUCT_PAIR_OUT == $past(reg_prod, 2))
        else $error("register form product wrong");
    chk_hn_kept: assert property ((taken && SRC_FORM_IN == 4'h0) |-> ##2
        FLAGS_OUT[SBP_FLAG_H] == $past(FLAGS_IN[SBP_FLAG_H], 2) && FLAGS_OUT[SBP_FLAG_N] == $past(FLAGS_IN[SBP_FLAG_N], 2))
        else $error("half-carry or subtract flag changed");
    chk_direct_addr: assert property ((taken && SRC_FORM_IN == 4'h4) |=>
        ADDR_VALID_OUT && ADDR_OUT == $past(DISP_IN))
        else $error("direct address not issued");
    chk_err_no_write: assert property (FORM_ERR_OUT |-> !PRODUCT_WE_OUT ##1 !PRODUCT_WE_OUT)
        else $error("product written on a field error");
endmodule // sbp_top_chk
bind sbp_top sbp_top_chk i_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .START_IN(START_IN),
    .SRC_FORM_IN(SRC_FORM_IN), .ACC_IN(ACC_IN), .REG_IN(REG_IN), .FLAGS_IN(FLAGS_IN), .DISP_IN(DISP_IN),
    .ADDR_OUT(ADDR_OUT), .ADDR_VALID_OUT(ADDR_VALID_OUT), .PRODUCT_PAIR_OUT(PRODUCT_PAIR_OUT),
    .PRODUCT_WE_OUT(PRODUCT_WE_OUT), .FLAGS_OUT(FLAGS_OUT), .FLAGS_WE_OUT(FLAGS_WE_OUT),
    .DONE_OUT(DONE_OUT), .FORM_ERR_OUT(FORM_ERR_OUT));
`default_nettype wire

//--- bench/sbp_tb_top.sv
// Self-checking testbench for the signed byte multiply datapath.
`timescale 1ns/1ps
`default_nettype none
module sbp_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, idx = 1'b0, mv = 1'b0;
    logic [3:0]  form = 4'h0;
    logic [7:0]  acc = 8'h00, rg = 8'h00, imm = 8'h00, fl = 8'h00, md = 8'h00;
    logic [2:0]  hs = 3'h4, ls = 3'h1, bs = 3'h1;
    logic [15:0] fx = 16'h12f3, sx = 16'h3481, pr = 16'h0450, sp = 16'h8000, pc = 16'h0100, ds = 16'hfff0;
    logic [15:0] addr, prod;
    logic [7:0]  flo;
    logic        av, pwe, fwe, done, err;
    int          failures = 0, samples_checked = 0;
    // Clock at 25 MHz.
    always #20 clk = ~clk;
    sbp_top i_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .START_IN(start), .SRC_FORM_IN(form), .ACC_IN(acc),
        .REG_IN(rg), .IMM_IN(imm), .IDX_SEL_IN(idx), .HALF_SEL_IN(hs), .LONG_INDEX_SEL_IN(ls),
        .BASE_INDEX_SEL_IN(bs), .FIRST_INDEX_IN(fx), .SECOND_INDEX_IN(sx), .PRODUCT_PAIR_IN(pr), .SP_IN(sp),
        .PC_IN(pc), .DISP_IN(ds), .FLAGS_IN(fl), .MEM_VALID_IN(mv), .MEM_DATA_IN(md), .ADDR_OUT(addr),
        .ADDR_VALID_OUT(av), .PRODUCT_PAIR_OUT(prod), .PRODUCT_WE_OUT(pwe), .FLAGS_OUT(flo),
        .FLAGS_WE_OUT(fwe), .DONE_OUT(done), .FORM_ERR_OUT(err));
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One start; the wanted source byte s is offered only on the path the form should use.
    task automatic run_op(input logic [3:0] f, input logic [7:0] a, input logic [7:0] s, input logic [15:0] ea);
        logic [15:0] p;
        logic [7:0]  fi;
        int          n;
        p = 16'($signed(a) * $signed(s));
        fi = a ^ s;
        @(posedge clk);
        start <= 1'b1; form <= f; acc <= a; fl <= fi;
        rg <= (f == 4'h0) ? s : ~s;
        imm <= (f == 4'h2) ? s : ~s;
        @(posedge clk);
        start <= 1'b0;
        if (f > 4'h2) begin
            #1 check(16'(av), 16'h0001);
            check(addr, ea);
            @(posedge clk);
            mv <= 1'b1; md <= s;
            @(posedge clk);
            mv <= 1'b0; md <= ~s;
            // The read request must drop on the edge that takes the memory byte.
            #1 check(16'(av), 16'h0000);
        end
        n = 0;
        #1 while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 8) begin
            failures++;
            close_out();
        end
        check(prod, p);
        check(16'({pwe, fwe}), 16'h0003);
        check(16'(flo), 16'({p[15], p == 16'h0, fi[5:3], 1'b0, fi[1], ~(&p[15:7] | ~|p[15:7])}));
    endtask
    // Unsupported field codes end in an error pulse and leave the product alone.
    task automatic run_err(input logic [3:0] f);
        int n;
        @(posedge clk);
        start <= 1'b1; form <= f;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        #1 while (err !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1 n++;
        end
        check(16'({n < 4, done, pwe}), 16'h0004);
        check(prod, 16'hfff9);
        // A missing error pulse has already counted a mismatch; stop here rather than run on.
        if (n == 4) close_out();
    endtask
    // Signed register multiplies at sign and carry boundaries, each started in the cycle after the previous done pulse.
    task automatic test_reg_form();
        run_op(4'h0, 8'hfe, 8'h03, 16'h0);
        run_op(4'h0, 8'h80, 8'h80, 16'h0);
        run_op(4'h0, 8'h80, 8'hff, 16'h0);
        run_op(4'h0, 8'hc0, 8'h02, 16'h0);
        run_op(4'h0, 8'h00, 8'h55, 16'h0);
        run_op(4'h0, 8'h7f, 8'h7f, 16'h0);
        $display("test register form done");
    endtask
    // Index halves and immediate; select fields change on a rising edge ahead of the start.
    task automatic test_reg_sources();
        @(posedge clk);
        hs <= 3'h4;
        idx <= 1'b0;
        run_op(4'h1, 8'h05, 8'h12, 16'h0);
        @(posedge clk);
        hs <= 3'h5;
        idx <= 1'b1;
        run_op(4'h1, 8'hff, 8'h81, 16'h0);
        run_op(4'h2, 8'h09, 8'hf7, 16'h0);
        $display("test register sources done");
    endtask
    // Every memory form with its address.
    task automatic test_mem_forms();
        run_op(4'h3, 8'h03, 8'h40, pr);
        run_op(4'h4, 8'hf0, 8'h10, ds);
        @(posedge clk);
        ls <= 3'h1;
        run_op(4'h5, 8'h11, 8'h22, fx + ds);
        @(posedge clk);
        ls <= 3'h2;
        run_op(4'h5, 8'h81, 8'h7f, sx + ds);
        @(posedge clk);
        idx <= 1'b0;
        run_op(4'h6, 8'h02, 8'hfe, fx + 16'hfff0);
        run_op(4'h7, 8'h01, 8'h00, pc + ds);
        run_op(4'h8, 8'hff, 8'h01, sp + ds);
        @(posedge clk);
        bs <= 3'h1;
        run_op(4'h9, 8'h40, 8'h04, pr + fx);
        @(posedge clk);
        bs <= 3'h2;
        run_op(4'h9, 8'hf9, 8'h01, pr + sx);
        $display("test memory forms done");
    endtask
    // Bad field codes; relies on the product of 16'hfff9 left by the last memory form.
    task automatic test_field_errors();
        @(posedge clk);
        hs <= 3'h3;
        run_err(4'h1);
        @(posedge clk);
        ls <= 3'h3;
        run_err(4'h5);
        @(posedge clk);
        bs <= 3'h0;
        run_err(4'h9);
        run_err(4'hf);
        $display("test field errors done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_reg_form();
        test_reg_sources();
        test_mem_forms();
        test_field_errors();
        close_out();
    end
endmodule // sbp_tb_top
`default_nettype wire
